// ===== core/nsc_map.svh
`ifndef NSC_MAP_SVH
`define NSC_MAP_SVH

// Register numbers used by configuration reads and writes
`define NSC_REG_DEVICE_ID 8'h00
`define NSC_REG_SW_DESC 8'h01
`define NSC_REG_SW_CONFIG 8'h04
`define NSC_REG_NODE_ID 8'h05
`define NSC_REG_SYNTH 8'h06
`define NSC_REG_SW_CLK_DIV 8'h07
`define NSC_REG_REF_CLK_DIV 8'h08
`define NSC_REG_JTAG_ID 8'h09
`define NSC_REG_USER_CODE 8'h0a
`define NSC_REG_DIR_LOW 8'h0c
`define NSC_REG_DIR_HIGH 8'h0d

// Switch configuration fields
`define NSC_CFG_CTL_LOCK_BIT 31
`define NSC_CFG_SYNTH_LOCK_BIT 8
`define NSC_CFG_HDR_BIT 0

// Synthesizer settings fields
`define NSC_SYN_NO_RESET_BIT 31
`define NSC_SYN_SKIP_LOCK_BIT 30
`define NSC_SYN_BYPASS_BIT 29
`define NSC_SYN_BOOT_JTAG_BIT 28
`define NSC_SYN_WR_MASK 32'hf39fff7f

// Reset values
`define NSC_RST_SYNTH 32'h0000_0000
`define NSC_RST_SW_CLK_DIV 16'h0000
`define NSC_RST_REF_CLK_DIV 16'h0003
`define NSC_RST_NODE_ID 16'h0000
`define NSC_RST_DIR 32'h0000_0000

// Timing
`define NSC_CLK_PERIOD_PS 5000
`define NSC_TILE_RST_NS 20
`define NSC_TILE_RST_CYC ((`NSC_TILE_RST_NS * 1000 + `NSC_CLK_PERIOD_PS - 1) / `NSC_CLK_PERIOD_PS)
`define NSC_BOOT_CAPTURE_CYC 2

`endif

// ===== core/nsc_node_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "nsc_map.svh"

module nsc_node_regs #(
  parameter logic [7:0] SWITCH_REVISION = 8'h01, // Arbitrary value
  parameter logic [7:0] SWITCH_VERSION = 8'h01, // Arbitrary value
  parameter logic [7:0] NUM_LINKS = 8'h08,
  parameter logic [7:0] NUM_SWITCH_PROCS = 8'h02,
  parameter logic [7:0] NUM_DEVICE_PROCS = 8'h02,
  parameter logic [31:0] JTAG_DEVICE_ID = 32'h0000_0001, // Arbitrary value
  parameter logic [17:0] METAL_ID = 18'h00001 // Arbitrary value
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire nsc_pkg::nsc_cfg_req_s i_cfg_req,
  output nsc_pkg::nsc_cfg_rsp_s o_cfg_rsp,
  input wire logic [7:0] i_boot_select_pins,
  input wire logic [13:0] i_otp_user_code,
  input wire logic i_synth_locked,
  output nsc_pkg::nsc_synth_s o_synth,
  output logic o_tile_reset,
  output logic o_one_byte_header,
  output logic [15:0] o_switch_clk_div,
  output logic [15:0] o_ref_clk_div,
  output logic [15:0] o_node_id,
  input wire logic i_route_valid,
  input wire logic [15:0] i_route_dest,
  output nsc_pkg::nsc_route_s o_route
);
  import nsc_pkg::*;

  localparam int TILE_RST_CYC = `NSC_TILE_RST_CYC;

  logic ctl_lock_q;
  logic synth_lock_q;
  logic hdr_one_q;
  logic [15:0] node_id_q;
  logic [31:0] synth_q;
  logic [15:0] sw_div_q;
  logic [15:0] ref_div_q;
  logic [31:0] dir_lo_q;
  logic [31:0] dir_hi_q;
  logic [7:0] boot_meta_q;
  logic [7:0] boot_sync_q;
  logic [7:0] boot_pins_q;
  logic [1:0] boot_cnt_q;
  logic lock_meta_q;
  logic lock_sync_q;
  nsc_seq_e state_q;
  nsc_seq_e state_d;
  logic [2:0] rst_cnt_q;
  logic rst_q;
  logic wr;
  logic wr_ok;
  logic synth_wr;
  logic known;
  logic [31:0] rdata_d;
  nsc_cfg_rsp_s rsp_q;
  nsc_route_s route_q;

  // Index of the top mismatching bit between two identifiers
  function automatic logic [3:0] top_mismatch(input logic [15:0] a, input logic [15:0] b);
    logic [15:0] diff;
    logic [3:0] idx;
    diff = a ^ b;
    idx = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (diff[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // Known register numbers
  function automatic logic is_mapped(input logic [7:0] r);
    return (r == `NSC_REG_DEVICE_ID) || (r == `NSC_REG_SW_DESC) ||
           (r == `NSC_REG_SW_CONFIG) || (r == `NSC_REG_NODE_ID) ||
           (r == `NSC_REG_SYNTH) || (r == `NSC_REG_SW_CLK_DIV) ||
           (r == `NSC_REG_REF_CLK_DIV) || (r == `NSC_REG_JTAG_ID) ||
           (r == `NSC_REG_USER_CODE) || (r == `NSC_REG_DIR_LOW) ||
           (r == `NSC_REG_DIR_HIGH);
  endfunction

  // Write qualification
  assign wr = i_cfg_req.valid && i_cfg_req.write;
  assign wr_ok = wr && !ctl_lock_q;
  assign synth_wr = wr_ok && !synth_lock_q && (i_cfg_req.regnum == `NSC_REG_SYNTH);
  assign known = is_mapped(i_cfg_req.regnum);

  // Boot pin synchroniser
  always_ff @(posedge i_clk) begin
    boot_meta_q <= i_boot_select_pins;
    boot_sync_q <= boot_meta_q;
  end

  // Lock indication synchroniser
  always_ff @(posedge i_clk) begin
    lock_meta_q <= i_synth_locked;
    lock_sync_q <= lock_meta_q;
  end

  // Boot pins are caught once, shortly after reset release
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      boot_cnt_q <= 2'h0;
      boot_pins_q <= 8'h00;
    end else if (boot_cnt_q != 2'h3) begin
      boot_cnt_q <= boot_cnt_q + 2'h1;
      if (boot_cnt_q == 2'(`NSC_BOOT_CAPTURE_CYC)) begin
        boot_pins_q <= boot_sync_q;
      end
    end
  end

  // Switch configuration: locks and header mode
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ctl_lock_q <= 1'b0;
      synth_lock_q <= 1'b0;
      hdr_one_q <= 1'b0;
    end else if (wr_ok && i_cfg_req.regnum == `NSC_REG_SW_CONFIG) begin
      ctl_lock_q <= i_cfg_req.wdata[`NSC_CFG_CTL_LOCK_BIT];
      synth_lock_q <= i_cfg_req.wdata[`NSC_CFG_SYNTH_LOCK_BIT];
      hdr_one_q <= i_cfg_req.wdata[`NSC_CFG_HDR_BIT];
    end
  end

  // Node identifier
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      node_id_q <= `NSC_RST_NODE_ID;
    end else if (wr_ok && i_cfg_req.regnum == `NSC_REG_NODE_ID) begin
      node_id_q <= i_cfg_req.wdata[15:0];
    end
  end

  // Synthesizer settings; reserved bits never stored
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      synth_q <= `NSC_RST_SYNTH;
    end else if (synth_wr) begin
      synth_q <= i_cfg_req.wdata & `NSC_SYN_WR_MASK;
    end
  end

  // Clock dividers
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sw_div_q <= `NSC_RST_SW_CLK_DIV;
      ref_div_q <= `NSC_RST_REF_CLK_DIV;
    end else begin
      if (wr_ok && i_cfg_req.regnum == `NSC_REG_SW_CLK_DIV) begin
        sw_div_q <= i_cfg_req.wdata[15:0];
      end
      if (wr_ok && i_cfg_req.regnum == `NSC_REG_REF_CLK_DIV) begin
        ref_div_q <= i_cfg_req.wdata[15:0];
      end
    end
  end

  // Direction tables
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      dir_lo_q <= `NSC_RST_DIR;
      dir_hi_q <= `NSC_RST_DIR;
    end else begin
      if (wr_ok && i_cfg_req.regnum == `NSC_REG_DIR_LOW) begin
        dir_lo_q <= i_cfg_req.wdata;
      end
      if (wr_ok && i_cfg_req.regnum == `NSC_REG_DIR_HIGH) begin
        dir_hi_q <= i_cfg_req.wdata;
      end
    end
  end

  // Read multiplexer; reserved fields read zero
  always_comb begin
    rdata_d = 32'h0000_0000;
    unique case (i_cfg_req.regnum)
      `NSC_REG_DEVICE_ID: rdata_d = {8'h00, boot_pins_q, SWITCH_REVISION, SWITCH_VERSION};
      `NSC_REG_SW_DESC: rdata_d = {8'h00, NUM_LINKS, NUM_SWITCH_PROCS, NUM_DEVICE_PROCS};
      `NSC_REG_SW_CONFIG: begin
        rdata_d[`NSC_CFG_CTL_LOCK_BIT] = ctl_lock_q;
        rdata_d[`NSC_CFG_SYNTH_LOCK_BIT] = synth_lock_q;
        rdata_d[`NSC_CFG_HDR_BIT] = hdr_one_q;
      end
      `NSC_REG_NODE_ID: rdata_d = {16'h0000, node_id_q};
      `NSC_REG_SYNTH: rdata_d = synth_q;
      `NSC_REG_SW_CLK_DIV: rdata_d = {16'h0000, sw_div_q};
      `NSC_REG_REF_CLK_DIV: rdata_d = {16'h0000, ref_div_q};
      `NSC_REG_JTAG_ID: rdata_d = JTAG_DEVICE_ID;
      `NSC_REG_USER_CODE: rdata_d = {i_otp_user_code, METAL_ID};
      `NSC_REG_DIR_LOW: rdata_d = dir_lo_q;
      `NSC_REG_DIR_HIGH: rdata_d = dir_hi_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Transaction answer, one cycle after the request
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rsp_q <= '0;
    end else begin
      rsp_q.ack <= i_cfg_req.valid;
      rsp_q.err <= i_cfg_req.valid && (!known || (wr && ctl_lock_q));
      rsp_q.rdata <= (i_cfg_req.valid && !i_cfg_req.write) ? rdata_d : 32'h0000_0000;
    end
  end

  // Synthesizer update sequence: apply, optionally wait lock, then reset tile unless the no-reset bit is set
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: state_d = ST_IDLE;
      ST_APPLY: begin
        if (!synth_q[`NSC_SYN_SKIP_LOCK_BIT]) begin
          state_d = ST_WAIT_LOCK;
        end else if (synth_q[`NSC_SYN_NO_RESET_BIT]) begin
          state_d = ST_IDLE;
        end else begin
          state_d = ST_RESET;
        end
      end
      ST_WAIT_LOCK: begin
        if (lock_sync_q) begin
          state_d = synth_q[`NSC_SYN_NO_RESET_BIT] ? ST_IDLE : ST_RESET;
        end
      end
      ST_RESET: begin
        if (rst_cnt_q == 3'(TILE_RST_CYC - 1)) begin
          state_d = ST_IDLE;
        end
      end
    endcase
    if (synth_wr) begin
      state_d = ST_APPLY;
    end
  end

  // Sequence state and reset pulse
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q <= ST_IDLE;
      rst_cnt_q <= 3'h0;
      rst_q <= 1'b0;
    end else begin
      state_q <= state_d;
      rst_q <= (state_d == ST_RESET);
      rst_cnt_q <= (state_q == ST_RESET) ? rst_cnt_q + 3'h1 : 3'h0;
    end
  end

  // Routing decision, registered
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      route_q <= '0;
    end else begin
      route_q.valid <= i_route_valid;
      route_q.local_hit <= (i_route_dest == node_id_q);
      if (i_route_dest == node_id_q) begin
        route_q.dir <= 4'h0;
      end else if (top_mismatch(i_route_dest, node_id_q) > 4'h7) begin
        route_q.dir <= 4'(dir_hi_q >> {top_mismatch(i_route_dest, node_id_q) - 4'h8, 2'b00});
      end else begin
        route_q.dir <= 4'(dir_lo_q >> {top_mismatch(i_route_dest, node_id_q), 2'b00});
      end
    end
  end

  // Outputs
  assign o_cfg_rsp = rsp_q;
  assign o_tile_reset = rst_q;
  assign o_one_byte_header = hdr_one_q;
  assign o_switch_clk_div = sw_div_q;
  assign o_ref_clk_div = ref_div_q;
  assign o_node_id = node_id_q;
  assign o_route = route_q;
  assign o_synth.skip_relock = synth_q[`NSC_SYN_SKIP_LOCK_BIT];
  assign o_synth.bypass = synth_q[`NSC_SYN_BYPASS_BIT];
  assign o_synth.boot_jtag = synth_q[`NSC_SYN_BOOT_JTAG_BIT];
  assign o_synth.out_div = synth_q[25:23];
  assign o_synth.fb_mult = synth_q[20:8];
  assign o_synth.in_div = synth_q[6:0];

  // Checks
  a_boot_pins_held: assert property (@(posedge i_clk) disable iff (i_reset)
    (boot_cnt_q == 2'h3) |=> $stable(boot_pins_q))
    else $error("boot pins changed after capture");

  a_ident_reserved: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_cfg_req.valid && !i_cfg_req.write && i_cfg_req.regnum == `NSC_REG_DEVICE_ID)
    |=> (o_cfg_rsp.rdata[31:24] == 8'h00) && (o_cfg_rsp.rdata[15:0] ==
    {SWITCH_REVISION, SWITCH_VERSION}))
    else $error("identification read wrong");

  a_ctl_lock_blocks: assert property (@(posedge i_clk) disable iff (i_reset)
    (wr && ctl_lock_q) |=> $stable(node_id_q) && $stable(dir_lo_q) && ctl_lock_q)
    else $error("write passed the control lock");

  a_synth_lock_blocks: assert property (@(posedge i_clk) disable iff (i_reset)
    (wr && synth_lock_q && i_cfg_req.regnum == `NSC_REG_SYNTH) |=> $stable(synth_q))
    else $error("synthesizer write passed its lock");

  a_header_mode: assert property (@(posedge i_clk) disable iff (i_reset)
    (wr_ok && i_cfg_req.regnum == `NSC_REG_SW_CONFIG)
    |=> (o_one_byte_header == $past(i_cfg_req.wdata[0])))
    else $error("header mode not taken");

  a_tile_reset_pulse: assert property (@(posedge i_clk) disable iff (i_reset)
    (synth_wr && i_cfg_req.wdata[31:30] == 2'b01)
    ##1 !synth_wr ##1 !synth_wr |-> o_tile_reset [*4] ##1 !o_tile_reset)
    else $error("tile reset pulse wrong");

  a_reset_suppressed: assert property (@(posedge i_clk) disable iff (i_reset)
    (synth_wr && i_cfg_req.wdata[31]) ##1 !synth_wr [*3]
    |-> !o_tile_reset [*3])
    else $error("reset not suppressed");

  a_wait_relock: assert property (@(posedge i_clk) disable iff (i_reset)
    (state_q == ST_WAIT_LOCK && !lock_sync_q) |=> !o_tile_reset)
    else $error("reset before re-lock");

  a_route_local: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_route_valid && i_route_dest == node_id_q) |=> o_route.valid && o_route.local_hit)
    else $error("local packet not delivered locally");

  a_route_top_bit: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_route_valid && (i_route_dest ^ node_id_q) == 16'h8000)
    |=> (o_route.dir == $past(dir_hi_q[31:28])) && !o_route.local_hit)
    else $error("top dimension direction wrong");

  a_route_dim0: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_route_valid && (i_route_dest ^ node_id_q) == 16'h0001)
    |=> (o_route.dir == $past(dir_lo_q[3:0])))
    else $error("dimension zero direction wrong");

  // Every configuration request is answered on the next cycle
  a_cfg_answer: assert property (@(posedge i_clk) disable iff (i_reset)
    i_cfg_req.valid |=> o_cfg_rsp.ack)
    else $error("configuration request not answered");

  // Upper half of the node identifier word always reads zero
  a_reserved_zero: assert property (@(posedge i_clk) disable iff (i_reset)
    (i_cfg_req.valid && !i_cfg_req.write && i_cfg_req.regnum == `NSC_REG_NODE_ID)
    |=> (o_cfg_rsp.rdata[31:16] == 16'h0000) && !o_cfg_rsp.err)
    else $error("reserved node identifier bits not zero");

endmodule
`default_nettype wire

// ===== core/nsc_pkg.sv
package nsc_pkg;

  // One configuration transaction
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] regnum;
    logic [31:0] wdata;
  } nsc_cfg_req_s;

  // Answer to a configuration transaction
  typedef struct packed {
    logic ack;
    logic err;
    logic [31:0] rdata;
  } nsc_cfg_rsp_s;

  // Synthesizer settings driven to the clock generator
  typedef struct packed {
    logic skip_relock;
    logic bypass;
    logic boot_jtag;
    logic [2:0] out_div;
    logic [12:0] fb_mult;
    logic [6:0] in_div;
  } nsc_synth_s;

  // Routing answer
  typedef struct packed {
    logic valid;
    logic local_hit;
    logic [3:0] dir;
  } nsc_route_s;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_APPLY,
    ST_WAIT_LOCK,
    ST_RESET
  } nsc_seq_e;

endpackage

// ===== sim/node_switch_config_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

module node_switch_config_regs_tb;
  import nsc_pkg::*;
  logic i_clk, i_reset, i_synth_locked, i_route_valid, o_tile_reset, o_one_byte_header, er;
  nsc_cfg_req_s i_cfg_req;
  nsc_cfg_rsp_s o_cfg_rsp;
  nsc_synth_s o_synth;
  nsc_route_s o_route;
  logic [7:0] i_boot_select_pins, boot_v;
  logic [13:0] i_otp_user_code;
  logic [15:0] i_route_dest, o_switch_clk_div, o_ref_clk_div, o_node_id;
  logic [31:0] seed = 32'h0001_6f90; // 94096
  logic [31:0] rd, w, sv, node_v, lo_v, hi_v;
  logic [7:0] regs [11] = '{8'h00, 8'h01, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0a,
    8'h0c, 8'h0d};
  logic [7:0] bad [5] = '{8'h02, 8'h03, 8'h0b, 8'h0e, 8'hff};
  int n_errors = 0;
  int checked = 0;
  int cyc = 0;
  int k;

  nsc_node_regs i_nsc_node_regs (.i_clk(i_clk), .i_reset(i_reset), .i_cfg_req(i_cfg_req),
    .o_cfg_rsp(o_cfg_rsp), .i_boot_select_pins(i_boot_select_pins),
    .i_otp_user_code(i_otp_user_code), .i_synth_locked(i_synth_locked), .o_synth(o_synth),
    .o_tile_reset(o_tile_reset), .o_one_byte_header(o_one_byte_header),
    .o_switch_clk_div(o_switch_clk_div), .o_ref_clk_div(o_ref_clk_div), .o_node_id(o_node_id),
    .i_route_valid(i_route_valid), .i_route_dest(i_route_dest), .o_route(o_route));

  // Free-running 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Cut a hang short
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      close_out();
    end
  end

  // Repeatable xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Value each register shows after reset
  function automatic logic [31:0] rst_val(logic [7:0] r);
    case (r)
      8'h00: return {8'h00, boot_v, 8'h01, 8'h01};
      8'h01: return 32'h0008_0202;
      8'h08: return 32'h0000_0003;
      8'h09: return 32'h0000_0001;
      8'h0a: return {i_otp_user_code, 18'h00001};
      default: return 32'h0000_0000;
    endcase
  endfunction

  // Expected routing answer: valid, local hit, direction
  function automatic logic [5:0] exp_route(logic [15:0] dst);
    logic [15:0] x;
    logic [63:0] t;
    x = dst ^ node_v[15:0];
    t = {hi_v, lo_v};
    if (x == 16'h0000) return 6'h30;
    for (int d = 15; d >= 0; d--) if (x[d]) return {2'b10, t[4*d+:4]};
    return 6'h00;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One configuration transaction; answer is sampled half a cycle after it is taken
  task automatic cfg(input logic wr, input logic [7:0] r, input logic [31:0] d);
    @(negedge i_clk);
    i_cfg_req = '{1'b1, wr, r, d};
    @(negedge i_clk);
    i_cfg_req.valid = 1'b0;
    rd = o_cfg_rsp.rdata;
    er = o_cfg_rsp.err;
    check(32'(o_cfg_rsp.ack), 32'h1);
  endtask

  task automatic rd_chk(input logic [7:0] r, input logic [31:0] exp, input logic exp_err);
    cfg(1'b0, r, 32'h0);
    check(rd, exp);
    check(32'(er), 32'(exp_err));
  endtask

  task automatic route(input logic [15:0] dst);
    @(negedge i_clk);
    i_route_valid = 1'b1;
    i_route_dest = dst;
    @(negedge i_clk);
    i_route_valid = 1'b0;
    check(32'(o_route), 32'(exp_route(dst)));
  endtask

  // Count tile reset cycles over a window
  task automatic pulses(input int n_cyc, input int n);
    k = 0;
    repeat (n_cyc) begin
      @(negedge i_clk);
      if (o_tile_reset === 1'b1) k++;
    end
    check(32'(k), 32'(n));
  endtask

  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Main sequence
  initial begin
    i_reset = 1'b1;
    i_cfg_req = '0;
    i_route_valid = 1'b0;
    i_route_dest = 16'h0000;
    i_synth_locked = 1'b0;
    boot_v = 8'(rnd());
    i_boot_select_pins = boot_v;
    i_otp_user_code = 14'(rnd());
    repeat (12) @(negedge i_clk);
    i_reset = 1'b0;
    repeat (6) @(negedge i_clk);
    i_boot_select_pins = ~boot_v;
    // Reset values, then read-only places refuse writes
    foreach (regs[i]) rd_chk(regs[i], rst_val(regs[i]), 1'b0);
    foreach (regs[i]) if (i < 2 || i > 6 && i < 9) begin
      cfg(1'b1, regs[i], 32'hffff_ffff);
      rd_chk(regs[i], rst_val(regs[i]), 1'b0);
    end
    foreach (bad[i]) begin
      cfg(1'b1, bad[i], rnd());
      rd_chk(bad[i], 32'h0, 1'b1);
    end
    // Random writable contents and routing through them
    repeat (8) begin
      node_v = rnd();
      cfg(1'b1, 8'h05, node_v);
      node_v &= 32'h0000_ffff;
      rd_chk(8'h05, node_v, 1'b0);
      check(32'(o_node_id), node_v);
      w = rnd();
      cfg(1'b1, 8'h07, w);
      rd_chk(8'h07, w & 32'hffff, 1'b0);
      check(32'(o_switch_clk_div), 32'(w[15:0]));
      w = rnd();
      cfg(1'b1, 8'h08, w);
      rd_chk(8'h08, w & 32'hffff, 1'b0);
      check(32'(o_ref_clk_div), 32'(w[15:0]));
      lo_v = rnd();
      hi_v = rnd();
      cfg(1'b1, 8'h0c, lo_v);
      cfg(1'b1, 8'h0d, hi_v);
      rd_chk(8'h0c, lo_v, 1'b0);
      rd_chk(8'h0d, hi_v, 1'b0);
      repeat (4) route(16'(rnd()));
    end
    // Every dimension, then the local case
    for (int d = 0; d < 16; d++) route(node_v[15:0] ^ (16'h0001 << d));
    route(node_v[15:0]);
    // Header size with reserved bits written high
    cfg(1'b1, 8'h04, 32'h7fff_feff);
    rd_chk(8'h04, 32'h1, 1'b0);
    check(32'(o_one_byte_header), 32'h1);
    cfg(1'b1, 8'h04, 32'h0);
    check(32'(o_one_byte_header), 32'h0);
    // Synthesizer: skip relock, no reset, wait for lock
    for (int m = 0; m < 3; m++) begin
      w = (rnd() & 32'h339f_ff7f) | (m == 0 ? 32'h4000_0000 : m == 1 ? 32'hc000_0000 : 32'h0);
      cfg(1'b1, 8'h06, w | 32'h0c60_0080);
      if (m == 2) begin
        pulses(12, 0);
        i_synth_locked = 1'b1;
      end
      pulses(24, m == 1 ? 0 : 4);
      rd_chk(8'h06, w, 1'b0);
      check(32'(o_synth), 32'({w[30:28], w[25:23], w[20:8], w[6:0]}));
    end
    sv = w;
    // Synthesizer lock drops writes quietly
    cfg(1'b1, 8'h04, 32'h0000_0100);
    cfg(1'b1, 8'h06, 32'h4000_0001);
    check(32'(er), 32'h0);
    pulses(12, 0);
    rd_chk(8'h06, sv, 1'b0);
    // Control lock refuses writes, itself included
    cfg(1'b1, 8'h04, 32'h8000_0100);
    cfg(1'b1, 8'h05, ~node_v);
    check(32'(er), 32'h1);
    rd_chk(8'h05, node_v, 1'b0);
    cfg(1'b1, 8'h04, 32'h0);
    check(32'(er), 32'h1);
    rd_chk(8'h04, 32'h8000_0100, 1'b0);
    // Second reset clears the lock and the identifier
    i_reset = 1'b1;
    repeat (3) @(negedge i_clk);
    i_reset = 1'b0;
    rd_chk(8'h04, 32'h0, 1'b0);
    rd_chk(8'h05, 32'h0, 1'b0);
    check(32'(o_node_id), 32'h0);
    close_out();
  end
endmodule

`default_nettype wire
